// >>> tb/pbw_src.sv
/*
  Model of the front-panel power switch and the wake sources.
  Assumes MCLK from the bench; every pin is a plain level, no pull-ups.
*/
`timescale 1ns/100ps
module pbw_src
  import pbw_pkg::*;
(
  input  wire logic MCLK,
  output logic      PWR_BTN_N,
  output logic      RTC_ALARM,
  output logic      LAN_WAKE,
  output logic      USB_WAKE,
  output logic      PCIE_WAKE_N,
  output logic      CIR_ACT,
  output logic      MIC_KWS,
  output logic      BT_ACT
);
  logic [6:0] lvl_r;
  logic       btn_r;

  // Every source idle and the switch released from time zero
  initial begin
    lvl_r = 7'h00;
    btn_r = 1'b0;
  end

  // Sources are levels; the switch and the PCIe line are low active
  assign PWR_BTN_N   = ~btn_r;
  assign RTC_ALARM   = lvl_r[W_RTC];
  assign LAN_WAKE    = lvl_r[W_LAN];
  assign USB_WAKE    = lvl_r[W_USB];
  assign PCIE_WAKE_N = ~lvl_r[W_PCIE];
  assign CIR_ACT     = lvl_r[W_CIR];
  assign MIC_KWS     = lvl_r[W_MIC];
  assign BT_ACT      = lvl_r[W_BT];

  // Raise or drop one source just after an edge
  task automatic level(input int unsigned idx, input logic on);
    @(posedge MCLK);
    lvl_r[idx] <= on;
  endtask

  // Hold the switch for a number of cycles; no bounce modelled
  task automatic press(input int unsigned hold);
    @(posedge MCLK);
    btn_r <= 1'b1;
    repeat (hold) @(posedge MCLK);
    btn_r <= 1'b0;
  endtask
endmodule

// >>> tb/power_button_wake_controller_tb.sv
/*
  Self-checking bench of the power button and wake controller.
  Assumes shortened press counts and the register map of pbw_pkg.
*/
`timescale 1ns/100ps
module power_button_wake_controller_tb;
  import pbw_pkg::*;
  typedef struct {
    logic [7:0]  ctrl;
    pbw_pst_t    tgt;
    int unsigned src;
    logic        wake;
    logic        mon;
  } pbw_row_t;
  logic             MCLK;
  logic             RST_N;
  logic [AW-1:0]    ADDR;
  logic [DW-1:0]    WDATA;
  logic             WR;
  logic             RD;
  logic [DW-1:0]    RDATA;
  logic [2:0]       PWR_STATE;
  logic             MON_ON, IRQ, btn_n, rtc, lan, usb, pcie_n, cir, mic, bt;
  int               err_total = 0;
  int               samples_checked = 0;
  int               cyc_cnt = 0;
  logic [7:0]       rd_v;
  // Wake matrix: setup, target state, source, woken, monitor lit
  pbw_row_t rows [20] = '{
    '{8'h00, PS_S0IX, W_RTC, 1, 0}, '{8'h00, PS_S5, W_RTC, 1, 0},
    '{8'h00, PS_S0IX, W_LAN, 0, 0}, '{8'h00, PS_S5, W_LAN, 1, 0},
    '{8'h00, PS_S3, W_LAN, 1, 0},   '{8'h08, PS_S5, W_LAN, 0, 0},
    '{8'h00, PS_S0IX, W_USB, 1, 1}, '{8'h00, PS_S3, W_USB, 1, 1},
    '{8'h00, PS_S4, W_USB, 0, 0},   '{8'h10, PS_S4, W_USB, 0, 0},
    '{8'h30, PS_S4, W_USB, 1, 1},   '{8'h10, PS_S5, W_USB, 1, 1},
    '{8'h14, PS_S5, W_USB, 0, 0},   '{8'h00, PS_S4, W_PCIE, 1, 0},
    '{8'h00, PS_S5, W_PCIE, 0, 0},  '{8'h00, PS_S4, W_CIR, 1, 1},
    '{8'h04, PS_S4, W_CIR, 0, 0},   '{8'h08, PS_S5, W_CIR, 0, 0},
    '{8'h00, PS_S0IX, W_MIC, 1, 1}, '{8'h00, PS_S3, W_MIC, 0, 0}
  };

  pbw_src src_u (.MCLK(MCLK), .PWR_BTN_N(btn_n), .RTC_ALARM(rtc),
    .LAN_WAKE(lan), .USB_WAKE(usb), .PCIE_WAKE_N(pcie_n), .CIR_ACT(cir),
    .MIC_KWS(mic), .BT_ACT(bt));

  // Small press counts keep long holds to a few dozen cycles
  pbw_ctrl #(.DEB_CYC(4), .SHORT_CYC(40), .LONG_CYC(60)) dut_u (
    .MCLK(MCLK), .RST_N(RST_N), .PWR_BTN_N(btn_n), .RTC_ALARM(rtc),
    .LAN_WAKE(lan), .USB_WAKE(usb), .PCIE_WAKE_N(pcie_n), .CIR_ACT(cir),
    .MIC_KWS(mic), .BT_ACT(bt), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .PWR_STATE(PWR_STATE), .MON_ON(MON_ON),
    .IRQ(IRQ));

  // 25 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  // Hang guard, far above the expected run length
  always @(posedge MCLK) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_total++;
      $display("unexpected at %0t: run did not finish", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  // Register port master: one-cycle strobes, data the cycle after RD
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge MCLK);
    WR    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge MCLK);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask

  // Bounded wait for a power state, then compare it
  // Look 1 ns after each edge so a state just launched is seen settled
  task automatic wst(input pbw_pst_t exp, input int n, input string msg);
    int i;
    i = 0;
    #1;
    while (i < n && PWR_STATE !== exp) begin
      @(posedge MCLK);
      #1;
      i++;
    end
    chk(8'(PWR_STATE), 8'(exp), msg);
  endtask

  initial begin
    RST_N <= 1'b0;
    ADDR  <= '0;
    WDATA <= '0;
    WR    <= 1'b0;
    RD    <= 1'b0;
    repeat (8) @(posedge MCLK);
    RST_N <= 1'b1;
    #1 chk({IRQ, MON_ON, 1'b0, PWR_STATE}, 8'h04, "reset outputs");
    rd(A_CTRL, rd_v);
    chk(rd_v, CTRL_RST, "ctrl reset");
    rd(A_STATUS, rd_v);
    chk(rd_v, 8'h14, "status reset");
    rd(8'h20, rd_v);
    chk(rd_v, 8'h00, "unmapped read");
    $display("test reset done");
    // USB is refused while the mains-loss flag stands
    wr(A_CTRL, 8'h11);
    src_u.level(W_USB, 1'b1);
    repeat (8) @(posedge MCLK);
    #1 chk(8'(PWR_STATE), 8'(PS_S5), "usb after g3");
    src_u.level(W_USB, 1'b0);
    src_u.press(20);
    wst(PS_S0, 30, "short press from off");
    wr(A_ISTAT, 8'h00);
    rd(A_ISTAT, rd_v);
    chk(rd_v & 8'h01, 8'h01, "wake status bit");
    $display("test g3 done");
    // Wake matrix; a refused source is followed by an alarm wake
    foreach (rows[i]) begin
      wr(A_CTRL, rows[i].ctrl);
      wr(A_CMD, 8'(rows[i].tgt));
      wst(rows[i].tgt, 4, "enter sleep");
      src_u.level(rows[i].src, 1'b1);
      wst(rows[i].wake ? PS_S0 : rows[i].tgt, 8, "wake");
      // Long enough for a refused source to pass the synchroniser
      repeat (6) @(posedge MCLK);
      #1 chk(8'(PWR_STATE), rows[i].wake ? 8'(PS_S0) : 8'(rows[i].tgt),
          "wake outcome");
      chk(8'(MON_ON), 8'(rows[i].mon), "monitor");
      src_u.level(rows[i].src, 1'b0);
      src_u.level(W_RTC, 1'b1);
      wst(PS_S0, 8, "return");
      src_u.level(W_RTC, 1'b0);
    end
    // Bluetooth is only a status level
    wr(A_CMD, 8'(PS_S0IX));
    src_u.level(W_BT, 1'b1);
    repeat (8) @(posedge MCLK);
    rd(A_STATUS, rd_v);
    chk(rd_v & 8'h27, 8'h21, "bluetooth");
    src_u.level(W_BT, 1'b0);
    src_u.press(20);
    wst(PS_S0, 30, "short press from sleep");
    $display("test wake matrix done");
    // Short press while working follows the sleep target
    wr(A_CTRL, 8'h01);
    src_u.press(20);
    wst(PS_S3, 30, "short press to sleep");
    src_u.press(20);
    wst(PS_S0, 30, "short press from sleep");
    // Held between the two limits: nothing at all
    src_u.press(50);
    repeat (30) @(posedge MCLK);
    #1 chk(8'(PWR_STATE), 8'(PS_S0), "mid-length press");
    $display("test press done");
    // Long hold forces off and raises the interrupt
    wr(A_ICLR, 8'h07);
    wr(A_IEN, 8'h04);
    src_u.press(80);
    wst(PS_S5, 10, "forced off");
    #1 chk(8'(IRQ), 8'h01, "irq on forced off");
    wr(A_ISTAT, 8'h00);
    wr(A_ICLR, 8'h04);
    @(posedge MCLK);
    #1 chk(8'(IRQ), 8'h00, "irq cleared");
    $display("test forced off done");
    // Other sleep targets, then long holds from sleep and from soft-off
    repeat (4) @(posedge MCLK);
    src_u.press(20);
    wst(PS_S0, 30, "short press from off");
    wr(A_CTRL, 8'h02);
    src_u.press(20);
    wst(PS_S4, 30, "short press to S4");
    src_u.press(20);
    wst(PS_S0, 30, "short press from S4");
    wr(A_CTRL, 8'h00);
    src_u.press(20);
    wst(PS_S0IX, 30, "short press to S0iX");
    src_u.press(80);
    wst(PS_S5, 10, "long press from sleep");
    // Let the release debounce before the next hold
    repeat (12) @(posedge MCLK);
    src_u.press(80);
    repeat (12) @(posedge MCLK);
    #1 chk(8'(PWR_STATE), 8'(PS_S5), "long press in soft-off");
    $display("test targets done");
    // Reset again mid-run: every register returns to its power-up value
    wr(A_IEN, 8'h07);
    wr(A_CTRL, 8'h3e);
    #1 chk(8'(IRQ), 8'h01, "irq before reset");
    @(posedge MCLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    #1 chk({IRQ, MON_ON, 1'b0, PWR_STATE}, 8'h04, "outputs after reset");
    rd(A_IEN, rd_v);
    chk(rd_v, 8'h00, "enable after reset");
    rd(A_CTRL, rd_v);
    chk(rd_v, CTRL_RST, "ctrl after reset");
    @(posedge MCLK);
    #1 chk(RDATA, 8'h00, "read data one cycle only");
    rd(A_STATUS, rd_v);
    chk(rd_v, 8'h14, "status after reset");
    $display("test mid reset done");
    stop_test();
  end
endmodule

// >>> verilog/pbw_ctrl.sv
/*
  Power button and wake controller top: power state machine, wake
  source qualification, register port and interrupt.
  Assumes a free-running standby MCLK at 25 MHz; switch and wake pins asynchronous, register port synchronous to MCLK.
*/
// The placing of the registers and the strobed register port were left to the implementer.
// Functional notes
// - Short press in soft-off or sleep moves the system to working.
// - Short press while working enters the configured sleep target.
// - Press over six seconds in working or sleep forces soft-off.
// - Power switch and RTC alarm wake from every sleep state.
// - LAN wakes from S3, S4, S5, not S0iX; monitor stays off.
// - USB wakes S0iX and S3; S4/S5 gated; never after G3.
// - PCIe wake works from S0iX, S3, S4 but not S5.
// - Infrared wakes from all sleep states except deep S4/S5.
// - Bluetooth activity never wakes the system.
// - Microphone keyword wake only from S0iX.
// - USB never wakes deep S4/S5; S4 also needs the OS enable.
// - Fast-startup shutdown blocks LAN, USB, infrared wake from S5.
`timescale 1ns/100ps
module pbw_ctrl #(
  parameter int unsigned DEB_CYC   = pbw_pkg::DEB_CYC,
  parameter int unsigned SHORT_CYC = pbw_pkg::SHORT_CYC,
  parameter int unsigned LONG_CYC  = pbw_pkg::LONG_CYC
) (
  input  wire logic                   MCLK,
  input  wire logic                   RST_N,
  input  wire logic                   PWR_BTN_N,
  input  wire logic                   RTC_ALARM,
  input  wire logic                   LAN_WAKE,
  input  wire logic                   USB_WAKE,
  input  wire logic                   PCIE_WAKE_N,
  input  wire logic                   CIR_ACT,
  input  wire logic                   MIC_KWS,
  input  wire logic                   BT_ACT,
  input  wire logic [pbw_pkg::AW-1:0] ADDR,
  input  wire logic [pbw_pkg::DW-1:0] WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [pbw_pkg::DW-1:0] RDATA,
  output logic      [2:0]             PWR_STATE,
  output logic                        MON_ON,
  output logic                        IRQ
);
  import pbw_pkg::*;

  typedef struct packed {
    logic [7:0]     s1;
    logic [7:0]     s2;
    pbw_pst_t       st;
    logic           mon;
    logic           g3;
    logic [7:0]     ctrl;
    logic [ISW-1:0] ist;
    logic [ISW-1:0] ien;
    logic [DW-1:0]  rdata;
    logic           irq;
  } pbw_top_t;

  localparam pbw_top_t RST_V = '{
    s1: 8'h00, s2: 8'h00, st: PS_S5, mon: 1'b0, g3: 1'b1,
    ctrl: CTRL_RST, ist: '0, ien: '0, rdata: '0, irq: 1'b0
  };

  pbw_top_t    s;
  pbw_top_t    n;
  pbw_press_if pif ();

  logic [7:0]     raw;
  logic [6:0]     wv;
  logic [1:0]     wd;
  logic           wr_cmd;
  logic           cmd_ok;
  logic           quiet;
  logic [ISW-1:0] ev;
  logic [ISW-1:0] clr;

  // Sleep target chosen by the OS power setting
  function automatic pbw_pst_t tgt_state(input logic [1:0] t);
    pbw_pst_t r;
    r = PS_S4;
    if (t == 2'h0) begin
      r = PS_S0IX;
    end else if (t == 2'h1) begin
      r = PS_S3;
    end
    return r;
  endfunction

  // Qualify wake sources for a sleep state: {wake, monitor on}
  function automatic logic [1:0] wake_dec(
    input logic [6:0] w,
    input pbw_pst_t   st,
    input logic [7:0] c,
    input logic       g3
  );
    logic deep;
    logic fast;
    logic usb_ok;
    logic wk;
    logic mon;
    deep = c[C_DEEP] && (st == PS_S4 || st == PS_S5);
    fast = c[C_FAST] && (st == PS_S5);
    wk   = 1'b0;
    mon  = 1'b0;
    usb_ok = (st == PS_S0IX) || (st == PS_S3) ||
             (st == PS_S4 && c[C_USB_FW] && c[C_USB_OS]) ||
             (st == PS_S5 && c[C_USB_FW]);
    // Alarm wakes everything but leaves the display dark
    if (w[W_RTC]) begin
      wk = 1'b1;
    end
    if (w[W_LAN] && st != PS_S0IX && !fast) begin
      wk = 1'b1;
    end
    if (w[W_USB] && usb_ok && !g3 && !deep && !fast) begin
      wk  = 1'b1;
      mon = 1'b1;
    end
    if (w[W_PCIE] && st != PS_S5) begin
      wk = 1'b1;
    end
    if (w[W_CIR] && !deep && !fast) begin
      wk  = 1'b1;
      mon = 1'b1;
    end
    if (w[W_MIC] && st == PS_S0IX) begin
      wk  = 1'b1;
      mon = 1'b1;
    end
    // Bluetooth lane is deliberately never examined here
    return {wk, mon};
  endfunction

  // Pins into the first synchroniser stage, active high
  assign raw = {~PWR_BTN_N, BT_ACT, MIC_KWS, CIR_ACT, ~PCIE_WAKE_N,
                USB_WAKE, LAN_WAKE, RTC_ALARM};
  assign wv      = s.s2[6:0];
  assign pif.btn = s.s2[W_BTN];
  assign wr_cmd  = WR && (ADDR == A_CMD);
  assign cmd_ok  = WDATA[2:0] >= 3'(PS_S0IX) && WDATA[2:0] <= 3'(PS_S5);
  assign quiet   = !pif.short_p && !pif.long_p && !wr_cmd;
  assign clr     = (WR && ADDR == A_ICLR) ? WDATA[ISW-1:0] : '0;

  pbw_press #(
    .DEB_CYC   (DEB_CYC),
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_press (
    .MCLK  (MCLK),
    .RST_N (RST_N),
    .pif   (pif)
  );

  // Next-state logic for the whole block
  always_comb begin
    n    = s;
    n.s1 = raw;
    n.s2 = s.s1;
    ev   = '0;
    wd   = wake_dec(wv, s.st, s.ctrl, s.g3);
    // Power state machine; long press outranks everything
    case (s.st)
      PS_S0: begin
        if (pif.long_p) begin
          n.st  = PS_S5;
          n.mon = 1'b0;
          ev[I_FORCE] = 1'b1;
        end else if (pif.short_p) begin
          n.st  = tgt_state(s.ctrl[C_TGT +: 2]);
          n.mon = 1'b0;
          ev[I_SLEEP] = 1'b1;
        end else if (wr_cmd && cmd_ok) begin
          n.st  = pbw_pst_t'(WDATA[2:0]);
          n.mon = 1'b0;
          ev[I_SLEEP] = 1'b1;
        end else if (wv[W_USB] || wv[W_CIR] || wv[W_MIC]) begin
          n.mon = 1'b1; // User activity relights a dark display
        end
      end
      PS_S5: begin
        // Already soft-off: a long press forces nothing, yet it still
        // outranks a wake pin seen in the same cycle
        if (pif.long_p) begin
          n.st = PS_S5;
        end else if (pif.short_p) begin
          n.st  = PS_S0;
          n.mon = 1'b1;
          ev[I_WAKE] = 1'b1;
        end else if (wd[1]) begin
          n.st  = PS_S0;
          n.mon = wd[0];
          ev[I_WAKE] = 1'b1;
        end
      end
      default: begin
        if (pif.long_p) begin
          n.st  = PS_S5;
          n.mon = 1'b0;
          ev[I_FORCE] = 1'b1;
        end else if (pif.short_p) begin
          n.st  = PS_S0;
          n.mon = 1'b1;
          ev[I_WAKE] = 1'b1;
        end else if (wd[1]) begin
          n.st  = PS_S0;
          n.mon = wd[0];
          ev[I_WAKE] = 1'b1;
        end
      end
    endcase
    // Reaching working ends the after-mains-loss period
    if (n.st == PS_S0) begin
      n.g3 = 1'b0;
    end
    // Register writes; control is read by the state logic and read back at A_CTRL
    if (WR) begin
      if (ADDR == A_CTRL) begin
        n.ctrl = WDATA;
      end else if (ADDR == A_IEN) begin
        n.ien = WDATA[ISW-1:0];
      end
    end
    // Sticky status: a new event beats a clear in the same cycle
    n.ist = (s.ist & ~clr) | ev;
    n.irq = |(n.ist & n.ien);
    // Read data valid only in the cycle after the strobe
    n.rdata = '0;
    if (RD) begin
      if (ADDR == A_CTRL) begin
        n.rdata = s.ctrl;
      end else if (ADDR == A_STATUS) begin
        n.rdata = {1'b0, pif.held, wv[W_BT], s.g3, s.mon, 3'(s.st)};
      end else if (ADDR == A_ISTAT) begin
        n.rdata = DW'(s.ist);
      end else if (ADDR == A_IEN) begin
        n.rdata = DW'(s.ien);
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s <= RST_V;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign RDATA     = s.rdata;
  assign PWR_STATE = 3'(s.st);
  assign MON_ON    = s.mon;
  assign IRQ       = s.irq;

  a_short_wake: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st != PS_S0 && pif.short_p && !pif.long_p)
      |=> (s.st == PS_S0) && s.mon)
    else $error("short press did not wake the system");
  a_short_sleep: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st == PS_S0 && pif.short_p && !pif.long_p)
      |=> s.st == tgt_state($past(s.ctrl[1:0])))
    else $error("short press did not enter the sleep target");
  a_long_off: assert property (@(posedge MCLK) disable iff (!RST_N)
    pif.long_p |=> (s.st == PS_S5) && !s.mon)
    else $error("long press did not force soft-off");
  a_rtc_dark: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st != PS_S0 && quiet && wv == 7'h01) |=> (s.st == PS_S0) && !s.mon)
    else $error("alarm wake wrong");
  a_lan_s0ix: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st == PS_S0IX && quiet && wv == 7'h02) |=> s.st == PS_S0IX)
    else $error("network wake honoured from S0iX");
  a_usb_g3: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.g3 && s.st == PS_S5 && quiet && wv == 7'h04) |=> s.st == PS_S5)
    else $error("USB wake honoured after mains loss");
  a_pcie_s5: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st == PS_S5 && quiet && wv == 7'h08) |=> s.st == PS_S5)
    else $error("PCIe wake honoured from S5");
  a_cir_deep: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.ctrl[C_DEEP] && (s.st == PS_S4 || s.st == PS_S5) && quiet &&
     wv == 7'h10) |=> $stable(s.st))
    else $error("infrared wake honoured from deep sleep");
  a_bt_never: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st != PS_S0 && quiet && wv == 7'h40) |=> $stable(s.st))
    else $error("Bluetooth woke the system");
  a_mic_s0ix: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st != PS_S0 && s.st != PS_S0IX && quiet && wv == 7'h20)
      |=> $stable(s.st))
    else $error("microphone wake outside S0iX");
  a_usb_s4_os: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st == PS_S4 && !s.ctrl[C_USB_OS] && quiet && wv == 7'h04)
      |=> s.st == PS_S4)
    else $error("USB S4 wake without OS enable");
  a_fast_block: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.ctrl[C_FAST] && s.st == PS_S5 && quiet && wv != 7'h00 &&
     (wv & 7'h69) == 7'h00) |=> s.st == PS_S5)
    else $error("fast-startup S5 woke on LAN, USB or infrared");

  // Event-bit, working-hold, mains-loss and lone-source checks; pins arrive here already two flops deep
  a_force_event: assert property (@(posedge MCLK) disable iff (!RST_N)
    (pif.long_p && s.st != PS_S5) |=> s.ist[I_FORCE])
    else $error("forced soft-off left no status bit");
  a_wake_event: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st != PS_S0 && pif.short_p && !pif.long_p) |=> s.ist[I_WAKE])
    else $error("short press wake left no status bit");
  a_sleep_event: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st == PS_S0 && pif.short_p && !pif.long_p)
      |=> s.ist[I_SLEEP] && !s.mon)
    else $error("sleep entry left status or monitor wrong");
  a_work_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st == PS_S0 && quiet) |=> s.st == PS_S0)
    else $error("working state left without a press or command");
  a_lan_s3: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st == PS_S3 && quiet && wv == 7'h02) |=> s.st == PS_S0)
    else $error("network wake refused from S3");
  a_lan_dark: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st != PS_S0 && quiet && wv == 7'h02) |=> !s.mon)
    else $error("network wake lit the monitor");
  a_usb_s0ix: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st == PS_S0IX && quiet && wv == 7'h04) |=> (s.st == PS_S0) && s.mon)
    else $error("USB wake refused from S0iX");
  a_usb_s5_fw: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st == PS_S5 && !s.ctrl[C_USB_FW] && quiet && wv == 7'h04)
      |=> s.st == PS_S5)
    else $error("USB wake from S5 without firmware enable");
  a_pcie_s4: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st == PS_S4 && quiet && wv == 7'h08) |=> s.st == PS_S0)
    else $error("PCIe wake refused from S4");
  a_pcie_s0ix: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st == PS_S0IX && quiet && wv == 7'h08) |=> (s.st == PS_S0) && !s.mon)
    else $error("PCIe wake from S0iX wrong");
  a_pcie_dark: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st != PS_S0 && quiet && wv == 7'h08) |=> !s.mon)
    else $error("PCIe wake lit the monitor");
  a_cir_s0ix: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st == PS_S0IX && quiet && wv == 7'h10) |=> (s.st == PS_S0) && s.mon)
    else $error("infrared wake refused from S0iX");
  a_mic_wake: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.st == PS_S0IX && quiet && wv == 7'h20) |=> (s.st == PS_S0) && s.mon)
    else $error("keyword wake refused from S0iX");
  a_usb_deep: assert property (@(posedge MCLK) disable iff (!RST_N)
    (s.ctrl[C_DEEP] && (s.st == PS_S4 || s.st == PS_S5) && quiet &&
     wv == 7'h04) |=> $stable(s.st))
    else $error("USB wake honoured from deep sleep");
  a_g3_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    s.st == PS_S0 |-> !s.g3)
    else $error("mains-loss flag still set while working");
endmodule

// >>> verilog/pbw_pkg.sv
/*
  Shared constants for the power button and wake controller: clock rate,
  press timing, register map, field positions and the power state type.
  Assumes a single always-on 25 MHz clock.
*/
package pbw_pkg;
  // Clock and press timing, times in ms
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned DEB_MS     = 20;
  localparam int unsigned SHORT_MS   = 4000;
  localparam int unsigned LONG_MS    = 6000;
  localparam int unsigned DEB_CYC    = DEB_MS * CYC_PER_MS;
  localparam int unsigned SHORT_CYC  = SHORT_MS * CYC_PER_MS;
  localparam int unsigned LONG_CYC   = LONG_MS * CYC_PER_MS;

  // Register port widths and offsets
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_CMD    = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_ISTAT  = 8'h0c;
  localparam logic [7:0] A_IEN    = 8'h10;
  localparam logic [7:0] A_ICLR   = 8'h14;

  // Control register fields
  localparam int unsigned C_TGT    = 0;
  localparam int unsigned C_DEEP   = 2;
  localparam int unsigned C_FAST   = 3;
  localparam int unsigned C_USB_FW = 4;
  localparam int unsigned C_USB_OS = 5;
  localparam logic [7:0]  CTRL_RST = 8'h01;

  // Status register fields
  localparam int unsigned S_MON  = 3;
  localparam int unsigned S_G3   = 4;
  localparam int unsigned S_BT   = 5;
  localparam int unsigned S_HELD = 6;

  // Interrupt bits
  localparam int unsigned ISW       = 3;
  localparam int unsigned I_WAKE    = 0;
  localparam int unsigned I_SLEEP   = 1;
  localparam int unsigned I_FORCE   = 2;

  // Synchroniser lanes
  localparam int unsigned W_RTC  = 0;
  localparam int unsigned W_LAN  = 1;
  localparam int unsigned W_USB  = 2;
  localparam int unsigned W_PCIE = 3;
  localparam int unsigned W_CIR  = 4;
  localparam int unsigned W_MIC  = 5;
  localparam int unsigned W_BT   = 6;
  localparam int unsigned W_BTN  = 7;

  typedef enum logic [2:0] {
    PS_S0, PS_S0IX, PS_S3, PS_S4, PS_S5
  } pbw_pst_t;
endpackage

// >>> verilog/pbw_press.sv
/*
  Power switch debouncer and press-duration timer.
  Assumes btn is synchronised, high while the switch is pressed.
*/
`timescale 1ns/100ps
module pbw_press #(
  parameter int unsigned DEB_CYC   = pbw_pkg::DEB_CYC,
  parameter int unsigned SHORT_CYC = pbw_pkg::SHORT_CYC,
  parameter int unsigned LONG_CYC  = pbw_pkg::LONG_CYC
) (
  input wire logic     MCLK,
  input wire logic     RST_N,
  pbw_press_if.tmr     pif
);
  import pbw_pkg::*;
  localparam int unsigned CW = $clog2(LONG_CYC + 1);
  localparam int unsigned DWD = $clog2(DEB_CYC + 1);
  localparam logic [CW-1:0]  SHORT_V = CW'(SHORT_CYC);
  localparam logic [CW-1:0]  LONG_V  = CW'(LONG_CYC);
  localparam logic [DWD-1:0] DEB_V   = DWD'(DEB_CYC);

  typedef struct packed {
    logic           d;
    logic [DWD-1:0] dcnt;
    logic [CW-1:0]  cnt;
    logic           lng;
    logic           sp;
    logic           lp;
  } pbw_prs_t;

  pbw_prs_t s;
  pbw_prs_t n;

  // Debounce, then time the debounced press
  always_comb begin
    n    = s;
    n.sp = 1'b0;
    n.lp = 1'b0;
    if (pif.btn != s.d) begin
      n.dcnt = s.dcnt + 1'b1;
      if (s.dcnt == DEB_V - 1'b1) begin
        n.d    = pif.btn;
        n.dcnt = '0;
      end
    end else begin
      n.dcnt = '0;
    end
    if (s.d) begin
      if (s.cnt != LONG_V) begin
        n.cnt = s.cnt + 1'b1;
      end
      if (s.cnt == LONG_V && !s.lng) begin
        n.lp  = 1'b1;
        n.lng = 1'b1;
      end
      if (!n.d) begin
        // Release: only under four seconds counts as a short press
        n.sp  = (s.cnt < SHORT_V);
        n.cnt = '0;
        n.lng = 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign pif.short_p = s.sp;
  assign pif.long_p  = s.lp;
  assign pif.held    = s.d;

  a_short_limit: assert property (@(posedge MCLK) disable iff (!RST_N)
    s.sp |-> $past(s.cnt) < SHORT_V)
    else $error("short press reported after the short limit");
  a_long_exact: assert property (@(posedge MCLK) disable iff (!RST_N)
    s.lp |-> ($past(s.cnt) == LONG_V) && $past(s.d))
    else $error("long press reported at the wrong count");
endmodule

// >>> verilog/pbw_press_if.sv
/*
  Carrier between the controller and its press timer.
  Assumes btn is already synchronised to MCLK.
*/
`timescale 1ns/100ps
interface pbw_press_if;
  logic btn;
  logic short_p;
  logic long_p;
  logic held;
  modport ctl (output btn, input short_p, input long_p, input held);
  modport tmr (input btn, output short_p, output long_p, output held);
endinterface
